// file: testbench/flash_cmd_front_tb_top.sv
// bench for the serial flash command front end
`timescale 1ns/10ps
module flash_cmd_front_tb_top;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        guard_n = 1'b1;
   logic        op_done = 1'b0;
   logic        pdata_ready = 1'b0;
   logic [7:0]  rd_data = 8'h00;
   logic        cs_n, sck, si, so, so_oe, op_req, pdata_valid, take;
   logic [18:0] op_addr, rd_addr;
   logic [7:0]  pdata, pd_seen;
   logic [15:0] rx_v, xd;
   logic [31:0] seed = 32'h00002BC2;
   logic [31:0] r, q;
   logic [23:0] a;
   logic [43:0] e;
   int          mismatches = 0;
   int          n_checks = 0;
   int          cnt = 0;
   logic [43:0] op_q[$];
   logic [7:0]  pd_q[$];
   logic [15:0] st_q[$];
   event        rx_ev;
   flash_front_pkg::op_kind_t op_kind;
   flash_front_pkg::op_kind_t knd[4] = '{flash_front_pkg::OP_SECTOR_ERASE,
      flash_front_pkg::OP_BLOCK_ERASE, flash_front_pkg::OP_CHIP_ERASE,
      flash_front_pkg::OP_BYTE_PROG};
   logic [7:0]  opc[4] = '{8'h20, 8'hD8, 8'h60, 8'h02};
   int          sh[4] = '{8, 8, 32, 0};
   wire         so_line = so_oe ? so : 1'bz;

   always #2.5 mclk = ~mclk;

   flash_cmd_front DUT (.mclk(mclk), .rst(rst), .clk_en(1'b1), .cs_n(cs_n),
      .sck(sck), .si(si), .guard_n(guard_n), .so(so), .so_oe(so_oe),
      .op_req(op_req), .op_kind(op_kind), .op_addr(op_addr),
      .op_done(op_done), .rd_addr(rd_addr), .rd_data(rd_data),
      .pdata(pdata), .pdata_valid(pdata_valid), .pdata_ready(pdata_ready));
   spi_host_model host (.so(so_line), .cs_n(cs_n), .sck(sck), .si(si));

   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task chk(input logic [43:0] seen, input logic [43:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t seen %h exp %h", $time, seen, exp);
      end
   endtask

   task final_report();
      if (op_q.size() + pd_q.size() + st_q.size() != 0) mismatches++;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task cmd(input logic [47:0] tx, input int nb);
      @(negedge mclk);
      host.xfer(tx, nb, 0, rx_v);
   endtask

   task rd(input logic [47:0] tx, input int nb, input logic [15:0] x);
      st_q.push_back(x);
      @(negedge mclk);
      host.xfer(tx, nb, 2, rx_v);
      ->rx_ev;
   endtask

   task rd_st(input logic [7:0] x);
      rd(48'h05, 8, {x, x});
   endtask

   task wsr(input logic [7:0] p, input logic [7:0] d);
      cmd(p, 8);
      cmd({8'h01, d}, 16);
   endtask

   // array side: slow completion, random drain of program data
   always @(negedge mclk) begin
      q = rnd();
      if (take)
         chk(pd_seen, pd_q.size() ? pd_q.pop_front() : 8'hxx);
      if (op_req === 1'b1) begin
         e = op_q.size() ? op_q.pop_front() : {44{1'b1}};
         chk({op_kind, op_addr} & e[43:22], e[21:0] & e[43:22]);
         cnt = 600;
      end else if (cnt > 0) cnt--;
      take = (pdata_valid === 1'b1) && q[0];
      pd_seen = pdata;
      pdata_ready <= q[0];
      op_done <= (cnt == 1);
      rd_data <= rd_addr[7:0] ^ 8'h5A;
   end

   always @(rx_ev)
      chk(rx_v, st_q.size() ? st_q.pop_front() : 16'hxxxx);

   initial begin
      #400000;
      mismatches++;
      final_report();
   end

   initial begin
      repeat (12) @(negedge mclk);
      rst = 1'b0;
      repeat (5) @(negedge mclk);
      rd_st(8'h1C);
      cmd(16'h0100, 16);
      rd_st(8'h1C);
      wsr(8'h06, 8'h63);
      rd_st(8'h00);
      wsr(8'h06, 8'h80);
      rd_st(8'h80);
      @(negedge mclk) guard_n = 1'b0;
      wsr(8'h06, 8'h9C);
      rd_st(8'h80);
      @(negedge mclk) guard_n = 1'b1;
      wsr(8'h50, 8'h00);
      rd_st(8'h00);
      @(negedge mclk) guard_n = 1'b0;
      wsr(8'h06, 8'h04);
      rd_st(8'h04);
      cmd(8'h06, 8);
      cmd(8'hC7, 8);
      rd_st(8'h06);
      cmd(8'h04, 8);
      wsr(8'h06, 8'h00);
      rd_st(8'h00);
      cmd(8'h03, 7);
      // write permit plus one stray bit must be dropped
      cmd(9'h00C, 9);
      rd_st(8'h00);
      cmd(8'h06, 8);
      rd_st(8'h02);
      cmd(8'h04, 8);
      rd_st(8'h00);
      cmd({8'h02, 24'h001234, 8'h55}, 40);
      rd_st(8'h00);
      for (int i = 0; i < 4; i++) begin
         r = rnd();
         a = {5'h00, r[18:16], (i == 3) ? r[15:0] : 16'h0000};
         cmd(8'h06, 8);
         op_q.push_back({3'h7, 19'h7FFFF, knd[i],
                         (i == 2) ? 19'h00000 : a[18:0]});
         if (i == 3) pd_q.push_back(r[31:24]);
         cmd({opc[i], a, r[31:24]} >> sh[i], 40 - sh[i]);
         rd_st(8'h03);
         repeat (700) @(negedge mclk);
         rd_st(8'h00);
      end
      r = rnd();
      a = {6'h00, r[17:1], 1'b0};
      cmd(8'h06, 8);
      op_q.push_back({22'h3FFFFF, flash_front_pkg::OP_AAI_WORD, a[18:0]});
      op_q.push_back({22'h3FFFFF, flash_front_pkg::OP_AAI_WORD,
                      a[18:0] + 19'h2});
      pd_q.push_back(r[31:24]);
      pd_q.push_back(r[27:20]);
      pd_q.push_back(r[15:8]);
      pd_q.push_back(r[7:0]);
      cmd({8'hAD, a, r[31:24], r[27:20]}, 48);
      repeat (700) @(negedge mclk);
      rd_st(8'h42);
      cmd({8'hAD, r[15:0]}, 24);
      repeat (700) @(negedge mclk);
      cmd(8'h04, 8);
      rd_st(8'h00);
      r = rnd();
      a = {5'h00, r[18:1], 1'b0};
      xd = {a[7:0] ^ 8'h5A, (a[7:0] + 8'h01) ^ 8'h5A};
      rd({8'h03, a}, 32, xd);
      rd({8'h0B, a, r[7:0]}, 40, xd);
      // let the read checker take the last note off its queue
      repeat (4) @(negedge mclk);
      final_report();
   end
endmodule // flash_cmd_front_tb_top

// file: testbench/spi_host_model.sv
// spi host model driving the flash front end link in mode 0
`timescale 1ns/10ps
module spi_host_model (
   input  wire logic so,
   output logic      cs_n,
   output logic      sck,
   output logic      si
);
   initial begin
      cs_n = 1'b1;
      sck  = 1'b0;
      si   = 1'b0;
   end
   // nb bits out msb first, then nrd bytes in; sck stands low between frames
   task automatic xfer(input logic [47:0] tx, input int nb, input int nrd,
                       output logic [15:0] rx);
      rx   = 16'h0000;
      cs_n = 1'b0;
      #40;
      for (int i = 0; i < nb + 8 * nrd; i++) begin
         si = (i < nb) ? tx[nb-1-i] : ~si;
         #32 sck = 1'b1;
         if (i >= nb) rx = {rx[14:0], so};
         #32 sck = 1'b0;
      end
      #40 cs_n = 1'b1;
      si = ~si;
      #200;
   endtask
endmodule // spi_host_model

// file: verilog/flash_cmd_front.sv
// serial flash command front end: link decode, status and write guard
`timescale 1ns/10ps
`include "flash_front_defs.svh"

// Functional notes
// - guard low and lock bit set: status write is refused
// - guard high: lock bit ignored, status write accepted
// - while busy only status reads are served
// - status bit 0 is busy, read-only, zero at power-up
// - status bit 1 is the write latch, read-only, zero at power-up
// - status bits 2..4 are protection level, writable, ones at power-up
// - status bit 5 reserved, reads zero, not writable
// - status bit 6 shows auto-increment mode, read-only, zero at power-up
// - lock bit set freezes protection level bits; lock bit writable
// - status write loads only protection level and lock bits, and clears the write latch
// - all status bits return to defaults at power-up
// - program and erase ignored while write latch is clear
// - write latch cleared at power-up, revoke, status write, op completion (for an AAI word only at the top address)
// - all bus cycles 8 bits, msb first, sampled on rising clock
// - each instruction starts at falling chip select
// - chip select rise inside a byte aborts the instruction
// - sector erase is 20h plus three address bytes
// - block erase is D8h plus three address bytes
// - auto-increment program is ADh, three address bytes, two data bytes
// - status read repeats status byte until chip select rises
// - chip erase only when all protection level bits are zero
module flash_cmd_front (
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic         clk_en,
   input  wire logic         cs_n,
   input  wire logic         sck,
   input  wire logic         si,
   input  wire logic         guard_n,
   output logic              so,
   output logic              so_oe,
   output logic              op_req,
   output flash_front_pkg::op_kind_t op_kind,
   output logic      [18:0]  op_addr,
   input  wire logic         op_done,
   output logic      [18:0]  rd_addr,
   input  wire logic [7:0]   rd_data,
   output logic      [7:0]   pdata,
   output logic              pdata_valid,
   input  wire logic         pdata_ready
);
   flash_front_pkg::ctl_t st;
   flash_front_pkg::ctl_t nx;
   logic [3:0]  pins;
   logic        cs_s;
   logic        sck_s;
   logic        si_s;
   logic        guard_s;
   logic        cs_fall;
   logic        cs_rise;
   logic        fin;
   logic        done_ok;
   logic        sck_rise;
   logic        sck_fall;
   logic        out_go;
   logic        push_v;
   logic        fifo_in_ready;
   logic        start;
   logic [7:0]  sh_new;
   logic [23:0] addr_new;
   logic [7:0]  out_byte;
   function automatic logic is_prot(input logic [2:0] bp,
                                    input logic [18:0] a);
      logic p;
      p = 1'b1;
      unique case (bp)
         3'h0:    p = 1'b0;
         3'h1:    p = (a[18:16] == 3'h7);
         3'h2:    p = (a[18:17] == 2'h3);
         3'h3:    p = a[18];
         default: p = 1'b1;
      endcase
      return p;
   endfunction
   function automatic logic [7:0] status_of(input logic busy,
                                            input logic write_latch_flag,
                                            input logic auto_increment_program,
                                            input logic protect_lock_bit,
                                            input logic [2:0] bp);
      logic [7:0] s;
      s = 8'h00;
      s[`SR_BUSY]            = busy;
      s[`SR_WEL]             = write_latch_flag;
      s[`SR_BP_HI:`SR_BP_LO] = bp;
      s[`SR_AAI]             = auto_increment_program;
      s[`SR_BPL]             = protect_lock_bit;
      return s;
   endfunction
   pin_sync #(
      .W (4)
   ) u_sync (
      .mclk   (mclk),
      .rst    (rst),
      .clk_en (clk_en),
      .din    ({cs_n, sck, si, guard_n}),
      .dout   (pins)
   );
   stream_fifo #(
      .W (`FIFO_W),
      .D (`FIFO_D)
   ) u_fifo (
      .mclk      (mclk),
      .rst       (rst),
      .clk_en    (clk_en),
      .in_valid  (push_v),
      .in_data   (st.pq[15:8]),
      .in_ready  (fifo_in_ready),
      .out_valid (pdata_valid),
      .out_data  (pdata),
      .out_ready (pdata_ready)
   );
   assign cs_s     = pins[3];
   assign sck_s    = pins[2];
   assign si_s     = pins[1];
   assign guard_s  = pins[0];
   assign cs_fall  = st.cs_d & ~cs_s;
   assign cs_rise  = ~st.cs_d & cs_s;
   assign fin      = cs_rise & st.act;
   assign done_ok  = fin & ~st.drop & (st.bit_cnt == 3'h0);
   assign sck_rise = st.act & ~cs_s & ~st.sck_d & sck_s;
   assign sck_fall = st.act & ~cs_s & st.sck_d & ~sck_s;
   assign sh_new   = {st.sh[6:0], si_s};
   assign addr_new = {st.addr[15:0], sh_new};
   assign out_go   = st.act & (((st.opc == `OPC_ST_READ)
                     & (st.byte_cnt != 3'h0))
                     | (~st.drop & (((st.opc == `OPC_READ)
                     & (st.byte_cnt >= `LEN_READ_DATA))
                     | ((st.opc == `OPC_FAST_READ)
                     & (st.byte_cnt >= `LEN_FAST_DATA)))));
   assign out_byte = (st.opc == `OPC_ST_READ)
                   ? status_of(st.busy, st.write_latch_flag, st.auto_increment_program, st.protect_lock_bit, st.bp)
                   : rd_data;
   always_comb begin
      nx        = st;
      nx.cs_d   = cs_s;
      nx.sck_d  = sck_s;
      nx.op_req = 1'b0;
      push_v    = 1'b0;
      start     = 1'b0;
      if (cs_fall) begin
         nx.act      = 1'b1;
         nx.drop     = st.busy;
         nx.bit_cnt  = 3'h0;
         nx.byte_cnt = 3'h0;
         nx.so_oe    = 1'b0;
      end
      if (cs_rise) begin
         nx.act   = 1'b0;
         nx.so_oe = 1'b0;
      end
      if (sck_rise) begin
         nx.sh      = sh_new;
         nx.bit_cnt = st.bit_cnt + 3'h1;
         if (st.bit_cnt == 3'h7) begin
            if (st.byte_cnt != 3'h7) begin
               nx.byte_cnt = st.byte_cnt + 3'h1;
            end
            case (st.byte_cnt)
               3'h0: nx.opc = sh_new;
               3'h1, 3'h2: nx.addr = addr_new;
               3'h3: begin
                  nx.addr    = addr_new;
                  nx.rd_addr = addr_new[18:0];
               end
               3'h4: nx.d0 = sh_new;
               3'h5: nx.d1 = sh_new;
               default: ;
            endcase
         end
      end
      if (sck_fall && out_go) begin
         nx.so_oe = 1'b1;
         if (st.bit_cnt == 3'h0) begin
            nx.so     = out_byte[7];
            nx.out_sh = {out_byte[6:0], 1'b0};
            if (st.opc != `OPC_ST_READ) begin
               nx.rd_addr = st.rd_addr + 19'h00001;
            end
         end else begin
            nx.so     = st.out_sh[7];
            nx.out_sh = {st.out_sh[6:0], 1'b0};
         end
      end
      unique case (st.ps)
         flash_front_pkg::PS_IDLE: ;
         flash_front_pkg::PS_PUSH: begin
            push_v = 1'b1;
            if (fifo_in_ready) begin
               nx.pq   = {st.pq[7:0], 8'h00};
               nx.pend = st.pend - 2'h1;
               if (st.pend == 2'h1) begin
                  nx.ps = flash_front_pkg::PS_REQ;
               end
            end
         end
         flash_front_pkg::PS_REQ: begin
            nx.op_req = 1'b1;
            nx.ps     = flash_front_pkg::PS_WAIT;
         end
         flash_front_pkg::PS_WAIT: begin
            if (op_done) begin
               nx.busy = 1'b0;
               nx.ps   = flash_front_pkg::PS_IDLE;
               if (st.kind != flash_front_pkg::OP_AAI_WORD
                   || st.top_pend) begin
                  nx.write_latch_flag = 1'b0;
                  nx.auto_increment_program = 1'b0;
               end
            end
         end
      endcase
      if (fin) begin
         nx.perm_prev = 1'b0;
      end
      if (done_ok) begin
         case (st.opc)
            `OPC_WR_PERMIT: if (st.byte_cnt == `LEN_ONE) begin
               nx.write_latch_flag       = 1'b1;
               nx.perm_prev = 1'b1;
            end
            `OPC_ST_PERMIT: if (st.byte_cnt == `LEN_ONE) begin
               nx.perm_prev = 1'b1;
            end
            `OPC_WR_REVOKE: if (st.byte_cnt == `LEN_ONE) begin
               nx.write_latch_flag = 1'b0;
               nx.auto_increment_program = 1'b0;
            end
            `OPC_ST_WRITE: if (st.byte_cnt == `LEN_ST_WRITE
                               && st.perm_prev) begin
               nx.write_latch_flag = 1'b0;
               if (guard_s || !st.protect_lock_bit) begin
                  nx.bp  = st.addr[`SR_BP_HI:`SR_BP_LO];
                  nx.protect_lock_bit = st.addr[`SR_BPL];
               end
            end
            `OPC_SECTOR_ERS, `OPC_BLOCK_ERS: begin
               if (st.byte_cnt == `LEN_ERASE && st.write_latch_flag
                   && !is_prot(st.bp, st.addr[18:0])) begin
                  start      = 1'b1;
                  nx.op_addr = st.addr[18:0];
                  nx.kind    = (st.opc == `OPC_SECTOR_ERS)
                             ? flash_front_pkg::OP_SECTOR_ERASE
                             : flash_front_pkg::OP_BLOCK_ERASE;
               end
            end
            `OPC_CHIP_ERS_A, `OPC_CHIP_ERS_B: begin
               if (st.byte_cnt == `LEN_ONE && st.write_latch_flag
                   && st.bp == 3'h0) begin
                  start      = 1'b1;
                  nx.op_addr = 19'h00000;
                  nx.kind    = flash_front_pkg::OP_CHIP_ERASE;
               end
            end
            `OPC_BYTE_PROG: begin
               if (st.byte_cnt == `LEN_BYTE_PROG && st.write_latch_flag
                   && !is_prot(st.bp, st.addr[18:0])) begin
                  start      = 1'b1;
                  nx.op_addr = st.addr[18:0];
                  nx.pq      = {st.d0, 8'h00};
                  nx.pend    = 2'h1;
                  nx.kind    = flash_front_pkg::OP_BYTE_PROG;
               end
            end
            `OPC_AAI_PROG: begin
               if (!st.auto_increment_program && st.byte_cnt == `LEN_AAI_FIRST && st.write_latch_flag
                   && !is_prot(st.bp, st.addr[18:0])) begin
                  start       = 1'b1;
                  nx.auto_increment_program      = 1'b1;
                  nx.op_addr  = st.addr[18:0];
                  nx.aai_addr = st.addr[18:0] + 19'h00002;
                  nx.top_pend = (st.addr[18:1] == 18'h3FFFF);
                  nx.pq       = {st.d0, st.d1};
                  nx.pend     = 2'h2;
                  nx.kind     = flash_front_pkg::OP_AAI_WORD;
               end else if (st.auto_increment_program && st.byte_cnt == `LEN_AAI_NEXT
                   && st.write_latch_flag && !is_prot(st.bp, st.aai_addr)) begin
                  start       = 1'b1;
                  nx.op_addr  = st.aai_addr;
                  nx.aai_addr = st.aai_addr + 19'h00002;
                  nx.top_pend = (st.aai_addr[18:1] == 18'h3FFFF);
                  nx.pq       = st.addr[15:0];
                  nx.pend     = 2'h2;
                  nx.kind     = flash_front_pkg::OP_AAI_WORD;
               end
            end
            default: ;
         endcase
         if (start) begin
            nx.busy = 1'b1;
            nx.ps   = (nx.pend != 2'h0) ? flash_front_pkg::PS_PUSH
                                        : flash_front_pkg::PS_REQ;
         end
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         st       <= '0;
         st.cs_d  <= 1'b1;
         st.sck_d <= 1'b1;
         st.bp    <= `SR_BP_RST;
      end else if (clk_en) begin
         st <= nx;
      end
   end
   assign so      = st.so;
   assign so_oe   = st.so_oe;
   assign op_req  = st.op_req;
   assign op_kind = st.kind;
   assign op_addr = st.op_addr;
   assign rd_addr = st.rd_addr;
   default clocking dc @(posedge mclk); endclocking
   default disable iff (rst);
   logic st_wr_done;
   assign st_wr_done = clk_en & done_ok & (st.opc == `OPC_ST_WRITE)
                     & (st.byte_cnt == `LEN_ST_WRITE) & st.perm_prev;
   sequence s_prog_taken;
      clk_en && done_ok && st.opc == `OPC_BYTE_PROG
      && st.byte_cnt == `LEN_BYTE_PROG && st.write_latch_flag
      && !is_prot(st.bp, st.addr[18:0]);
   endsequence
   sequence s_op_finish;
      clk_en && st.ps == flash_front_pkg::PS_WAIT && op_done;
   endsequence
   a_guard_lock: assert property (
      st_wr_done && !guard_s && st.protect_lock_bit |=> st.bp == $past(st.bp) && st.protect_lock_bit)
      else $error("status write accepted while locked");
   a_guard_open: assert property (
      st_wr_done && guard_s |=> st.bp == $past(st.addr[4:2])
      && st.protect_lock_bit == $past(st.addr[7]) && !st.write_latch_flag)
      else $error("status write refused with guard high");
   a_busy_quiet: assert property (
      st.drop && st.opc != `OPC_ST_READ |-> !so_oe)
      else $error("output driven for non-status command while busy");
   a_busy_ends: assert property (
      s_op_finish |=> !st.busy && st.ps == flash_front_pkg::PS_IDLE)
      else $error("busy not cleared on completion");
   a_latch_clear: assert property (
      s_op_finish ##0 st.kind != flash_front_pkg::OP_AAI_WORD |=> !st.write_latch_flag)
      else $error("write latch not cleared after operation");
   a_latch_gate: assert property (
      clk_en && fin && !st.write_latch_flag && !st.busy |=> !st.busy)
      else $error("write started with write latch clear");
   a_abort_short: assert property (
      clk_en && fin && st.bit_cnt != 3'h0 && st.ps != flash_front_pkg::PS_WAIT
      |=> $stable(st.write_latch_flag) && $stable(st.bp) && $stable(st.busy))
      else $error("partial byte frame took effect");
   a_chip_locked: assert property (
      clk_en && done_ok && (st.opc == `OPC_CHIP_ERS_A
      || st.opc == `OPC_CHIP_ERS_B) && st.bp != 3'h0 |=> !st.busy)
      else $error("chip erase ran with protection set");
   a_prog_start: assert property (
      s_prog_taken |-> ##[1:40] st.op_req)
      else $error("byte program request not issued");
   a_so_idle: assert property (
      !st.act |-> !so_oe)
      else $error("serial output driven outside a frame");
endmodule // flash_cmd_front

// file: verilog/flash_front_defs.svh
// constants of the serial flash command front end
`ifndef FLASH_FRONT_DEFS_SVH
`define FLASH_FRONT_DEFS_SVH

// opcodes
`define OPC_READ        8'h03
`define OPC_FAST_READ   8'h0B
`define OPC_SECTOR_ERS  8'h20
`define OPC_BLOCK_ERS   8'hD8
`define OPC_CHIP_ERS_A  8'h60
`define OPC_CHIP_ERS_B  8'hC7
`define OPC_BYTE_PROG   8'h02
`define OPC_AAI_PROG    8'hAD
`define OPC_ST_READ     8'h05
`define OPC_ST_PERMIT   8'h50
`define OPC_ST_WRITE    8'h01
`define OPC_WR_PERMIT   8'h06
`define OPC_WR_REVOKE   8'h04

// complete frame lengths in bytes, opcode included; for reads, the bytes before the data phase
`define LEN_ONE         3'h1
`define LEN_ST_WRITE    3'h2
`define LEN_AAI_NEXT    3'h3
`define LEN_ERASE       3'h4
`define LEN_BYTE_PROG   3'h5
`define LEN_AAI_FIRST   3'h6
`define LEN_READ_DATA   3'h4
`define LEN_FAST_DATA   3'h5

// status byte fields
`define SR_BUSY         0
`define SR_WEL          1
`define SR_BP_LO        2
`define SR_BP_HI        4
`define SR_RSVD         5
`define SR_AAI          6
`define SR_BPL          7
`define SR_BP_RST       3'h7

// array geometry and data buffer
`define ADDR_W          19
`define FIFO_W          8
`define FIFO_D          16

`endif

// file: verilog/flash_front_pkg.sv
// types shared by the serial flash command front end
package flash_front_pkg;

   typedef enum logic [2:0] {
      OP_NONE, OP_BYTE_PROG, OP_AAI_WORD,
      OP_SECTOR_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE
   } op_kind_t;

   typedef enum logic [1:0] {PS_IDLE, PS_PUSH, PS_REQ, PS_WAIT} push_state_t;

   typedef struct packed {
      logic        cs_d;
      logic        sck_d;
      logic        act;
      logic        drop;
      logic [2:0]  bit_cnt;
      logic [2:0]  byte_cnt;
      logic [7:0]  sh;
      logic [7:0]  opc;
      logic [23:0] addr;
      logic [7:0]  d0;
      logic [7:0]  d1;
      logic [7:0]  out_sh;
      logic        so;
      logic        so_oe;
      logic [18:0] rd_addr;
      logic        busy;
      logic        write_latch_flag;
      logic        auto_increment_program;
      logic [2:0]  bp;
      logic        protect_lock_bit;
      logic        perm_prev;
      push_state_t ps;
      logic [1:0]  pend;
      logic [15:0] pq;
      logic        top_pend;
      op_kind_t    kind;
      logic [18:0] op_addr;
      logic [18:0] aai_addr;
      logic        op_req;
   } ctl_t;

endpackage

// file: verilog/pin_sync.sv
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module pin_sync #(
   parameter int W = 4
) (
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic         clk_en,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_t;

   sync_t st;
   sync_t nx;

   always_comb begin
      nx    = st;
      nx.s1 = din;
      nx.s2 = st.s1;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st <= '1;
      end else if (clk_en) begin
         st <= nx;
      end
   end

   assign dout = st.s2;
endmodule // pin_sync

// file: verilog/stream_fifo.sv
// parameterised fifo with registered output stage
`timescale 1ns/10ps
module stream_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic         clk_en,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   output logic              out_valid,
   output logic      [W-1:0] out_data,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
      logic          ov;
      logic [W-1:0]  od;
   } fifo_t;

   fifo_t        st;
   fifo_t        nx;
   logic [W-1:0] mem [D];
   logic         push;
   logic         pop;

   assign in_ready = (st.cnt != (AW+1)'(D));
   assign push     = in_valid & in_ready;
   assign pop      = (st.cnt != '0) & (~st.ov | out_ready);

   always_comb begin
      nx = st;
      if (pop) begin
         nx.od = mem[st.rp];
         nx.ov = 1'b1;
         nx.rp = st.rp + AW'(1);
      end else if (out_ready) begin
         nx.ov = 1'b0;
      end
      if (push) begin
         nx.wp = st.wp + AW'(1);
      end
      nx.cnt = st.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st <= '0;
      end else if (clk_en) begin
         st <= nx;
         if (push) begin
            mem[st.wp] <= in_data;
         end
      end
   end

   assign out_valid = st.ov;
   assign out_data  = st.od;
endmodule // stream_fifo
